// >>> flwc_count.sv
// saturating cycle counter with synchronous clear
`timescale 1ns/100ps
module flwc_count #(
  parameter int W = 24
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  output logic      [W-1:0] q
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (clr) begin
      q <= '0;
    end else if (!(&q)) begin
      q <= q + W'(1);
    end
  end
endmodule // flwc_count

// >>> flwc_ctrl.sv
// single wire register link and led driver control of the flash driver
// What this block does
// (R01) line high enables the device, held low disables it
// (R02) each pulse on the line increments the word counter, which saturates at 63
// (R03) high inactive period after pulses latches the counted word
// (R04) address word then data word writes the addressed register
// (R05) line low longer than 405 us: shutdown and registers to default
// (R06) five writable registers: flash, torch, duration, low battery, threshold
// (R07) registers are write only, no read path
// (R08) rising edge of the flash trigger pin starts flash
// (R09) flash control register write also starts flash
// (R10) flash stops when trigger and register bit low, or timer expires
// (R11) flash level defaults to the 1 A code, code 0 is maximum
// (R12) torch starts on torch register write, stops on clear or timeout
// (R13) torch level selectable, default code 4 gives 300 mA
// (R14) safety timer cuts current only above programmed threshold
// (R15) low battery disables driver until recovery and command toggle
// (R16) overvoltage latches off until reset or line driven low
// (R17) 200 us short test before each enable, failure ignores command
// (R18) over temperature disables driver until cool and command toggle
// (R19) boost enable follows driver activation exactly
// (R20) idle keeps registers, leaving shutdown gives defaults
// (R21) word latched after line high for the latch timeout
// (R22) first falling edge in idle starts a frame, counter cleared
// (R23) only exactly two words then end period are processed
// (R24) addresses start at one, data above maximum discards the frame
// (R25) line synchronised, low and high times measured by counter
`timescale 1ns/100ps
module flwc_ctrl
  import flwc_pkg::*;
#(
  parameter int END_CYCLES   = END_CYC,
  parameter int SHORT_CYCLES = SHORT_CYC,
  parameter int SAFE_UNIT    = SAFE_UNIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       serial_enable_line,
  input  wire logic       flash_trigger_pin,
  input  wire logic       low_battery_detect,
  input  wire logic       output_overvoltage_protect,
  input  wire logic       temp_hot,
  input  wire logic       temp_cool,
  input  wire logic       led_short_fail,
  output logic            led_driver_en,
  output logic            boost_en,
  output logic            short_test_en,
  output logic            flash_mode,
  output logic      [3:0] led_level_code,
  output logic      [3:0] low_battery_code,
  output logic            shutdown
);
  localparam int CW = 24;
  localparam int TW = 28;

  // ----------------------------------------------------------------------
  // pin synchronisers and line timing
  // ----------------------------------------------------------------------
  logic [6:0]    pins_s;
  logic          dc_s;
  logic          dc_d_reg;
  logic          rise;
  logic          fall;
  logic [CW-1:0] line_q;
  logic          lat_hit;
  logic          end_hit;

  // (R25) line synchronised
  flwc_sync #(.W(7)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({led_short_fail, temp_cool, temp_hot,
                output_overvoltage_protect, low_battery_detect,
                flash_trigger_pin, serial_enable_line}),
    .q        (pins_s)
  );
  assign dc_s = pins_s[0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dc_d_reg <= 1'b0;
    end else begin
      dc_d_reg <= dc_s;
    end
  end
  assign rise = dc_s & ~dc_d_reg;
  assign fall = ~dc_s & dc_d_reg;

  // (R25) level duration counter
  flwc_count #(.W(CW)) u_line_cnt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (rise | fall),
    .q        (line_q)
  );
  assign lat_hit = (line_q == CW'(LAT_CYC));
  assign end_hit = (line_q == CW'(END_CYCLES));

  // ----------------------------------------------------------------------
  // frame receiver
  // ----------------------------------------------------------------------
  flwc_line_t ln_state_reg;
  logic [5:0] cnt_reg;
  logic [5:0] addr_sh_reg;
  logic [5:0] data_sh_reg;
  logic [1:0] words_reg;
  logic       err_reg;
  logic       shut_hit;
  logic       frame_end;
  logic       data_ok;
  logic       frame_ok;

  // (R05) low for the end time
  assign shut_hit  = !dc_s && end_hit && (ln_state_reg != LN_SHUT);
  assign frame_end = (ln_state_reg == LN_RX) && dc_s && end_hit;

  // (R24) per register maximum, address zero invalid
  always_comb begin
    case (addr_sh_reg)
      ADDR_FLASH: data_ok = (data_sh_reg <= MAX_FLASH);
      ADDR_TORCH: data_ok = (data_sh_reg <= MAX_TORCH);
      ADDR_DUR:   data_ok = (data_sh_reg <= MAX_DUR);
      ADDR_LB:    data_ok = (data_sh_reg <= MAX_LB);
      ADDR_THR:   data_ok = (data_sh_reg <= MAX_THR);
      default:    data_ok = 1'b0;
    endcase
  end
  // (R23) exactly two words
  assign frame_ok = frame_end && (words_reg == 2'd2) && !err_reg && data_ok;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ln_state_reg <= LN_SHUT;
      cnt_reg      <= 6'h00;
      addr_sh_reg  <= 6'h00;
      data_sh_reg  <= 6'h00;
      words_reg    <= 2'd0;
      err_reg      <= 1'b0;
    end else if (shut_hit) begin
      ln_state_reg <= LN_SHUT;
    end else begin
      case (ln_state_reg)
        // (R01) line high enables
        LN_SHUT: begin
          if (dc_s) begin
            ln_state_reg <= LN_IDLE;
          end
        end
        // (R22) start of frame
        LN_IDLE: begin
          if (fall) begin
            ln_state_reg <= LN_RX;
            cnt_reg      <= 6'h00;
            words_reg    <= 2'd0;
            err_reg      <= 1'b0;
          end
        end
        LN_RX: begin
          // (R02) count pulses
          if (rise && !(&cnt_reg)) begin
            cnt_reg <= cnt_reg + 6'h01;
          end
          // (R21) latch word
          if (dc_s && lat_hit) begin
            cnt_reg <= 6'h00;
            if (words_reg == 2'd0) begin
              addr_sh_reg <= cnt_reg;
            end else if (words_reg == 2'd1) begin
              data_sh_reg <= cnt_reg;
            end
            if (words_reg != 2'd3) begin
              words_reg <= words_reg + 2'd1;
            end
          end
          // low past the pulse window spoils the frame
          if (!dc_s && lat_hit) begin
            err_reg <= 1'b1;
          end
          // (R03) end period closes the frame
          if (frame_end) begin
            ln_state_reg <= LN_IDLE;
          end
        end
        default: ln_state_reg <= LN_SHUT;
      endcase
    end
  end
  assign shutdown = ln_state_reg[0];

  // ----------------------------------------------------------------------
  // write only registers, no read path exists
  // ----------------------------------------------------------------------
  logic [4:0] flash_reg;
  logic [4:0] torch_reg;
  logic [2:0] dur_reg;
  logic [3:0] lb_reg;
  logic [2:0] thr_reg;

  // (R06) five registers, (R07) write only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_reg <= FLASH_DEF;
      torch_reg <= TORCH_DEF;
      dur_reg   <= DUR_DEF;
      lb_reg    <= LB_DEF;
      thr_reg   <= THR_DEF;
    end else if (shut_hit) begin
      // (R20) shutdown restores defaults
      flash_reg <= FLASH_DEF;
      torch_reg <= TORCH_DEF;
      dur_reg   <= DUR_DEF;
      lb_reg    <= LB_DEF;
      thr_reg   <= THR_DEF;
    end else if (frame_ok) begin
      // (R04) apply data to address
      case (addr_sh_reg)
        ADDR_FLASH: flash_reg <= data_sh_reg[4:0];
        ADDR_TORCH: torch_reg <= data_sh_reg[4:0];
        ADDR_DUR:   dur_reg   <= data_sh_reg[2:0];
        ADDR_LB:    lb_reg    <= data_sh_reg[3:0];
        ADDR_THR:   thr_reg   <= data_sh_reg[2:0];
        default:    flash_reg <= flash_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // commands and fault latches
  // ----------------------------------------------------------------------
  logic flash_cmd;
  logic torch_cmd;
  logic fcmd_d_reg;
  logic tcmd_d_reg;
  logic start;
  logic toggle;
  logic ovp_reg;
  logic hot_reg;
  logic blocked;

  // (R08) pin edge, (R09) register enable bit
  assign flash_cmd = pins_s[1] | flash_reg[EN_BIT];
  // (R12) torch enable bit
  assign torch_cmd = torch_reg[EN_BIT];
  assign start  = (flash_cmd & ~fcmd_d_reg) | (torch_cmd & ~tcmd_d_reg);
  assign toggle = start | (fcmd_d_reg & ~flash_cmd)
                  | (tcmd_d_reg & ~torch_cmd);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcmd_d_reg <= 1'b0;
      tcmd_d_reg <= 1'b0;
    end else begin
      fcmd_d_reg <= flash_cmd;
      tcmd_d_reg <= torch_cmd;
    end
  end

  // (R16) overvoltage latch; a new event wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovp_reg <= 1'b0;
    end else if (pins_s[3]) begin
      ovp_reg <= 1'b1;
    end else if (!dc_s) begin
      ovp_reg <= 1'b0;
    end
  end

  // (R18) thermal latch, cleared when cool and commands toggle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hot_reg <= 1'b0;
    end else if (pins_s[4]) begin
      hot_reg <= 1'b1;
    end else if (pins_s[5] && toggle) begin
      hot_reg <= 1'b0;
    end
  end
  assign blocked = ovp_reg | hot_reg | pins_s[2] | shutdown;

  // ----------------------------------------------------------------------
  // driver sequencer
  // ----------------------------------------------------------------------
  flwc_drv_t     dr_state_reg;
  flwc_drv_t     dr_next;
  logic [TW-1:0] tmr_q;
  logic          test_done;
  logic [3:0]    level;
  logic          over_thr;
  logic [TW-1:0] saf_lim;
  logic          expire;

  assign level    = flash_cmd ? flash_reg[3:0] : torch_reg[3:0];
  // (R14) lower code means more current
  assign over_thr = (~level) > {thr_reg, 1'b0};
  assign saf_lim  = (TW'(dur_reg) + TW'(1)) * TW'(SAFE_UNIT);
  assign expire   = over_thr && (tmr_q >= saf_lim);
  assign test_done = (dr_state_reg == DR_TEST)
                     && (tmr_q == TW'(SHORT_CYCLES));

  // one timer serves both the short test and the safety timeout
  flwc_count #(.W(TW)) u_tmr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (test_done || !(dr_state_reg == DR_TEST
                               || dr_state_reg == DR_ON)),
    .q        (tmr_q)
  );

  always_comb begin
    dr_next = dr_state_reg;
    case (dr_state_reg)
      DR_OFF: begin
        if (start && !blocked) begin
          dr_next = DR_TEST;
        end
      end
      // (R17) short test, failure not latched
      DR_TEST: begin
        if (blocked) begin
          dr_next = DR_OFF;
        end else if (test_done) begin
          dr_next = (pins_s[6] || !(flash_cmd || torch_cmd)) ? DR_OFF
                                                               : DR_ON;
        end
      end
      // (R10) stop on command low, (R15) lock on fault or timeout
      DR_ON: begin
        if (blocked || expire) begin
          dr_next = DR_LOCK;
        end else if (!(flash_cmd || torch_cmd)) begin
          dr_next = DR_OFF;
        end
      end
      DR_LOCK: begin
        if (!(flash_cmd || torch_cmd)) begin
          dr_next = DR_OFF;
        end
      end
      default: dr_next = DR_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dr_state_reg <= DR_OFF;
    end else begin
      dr_state_reg <= dr_next;
    end
  end

  // (R19) boost tracks driver
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_driver_en <= 1'b0;
      boost_en      <= 1'b0;
      short_test_en <= 1'b0;
      flash_mode    <= 1'b0;
    end else begin
      led_driver_en <= (dr_next == DR_ON);
      boost_en      <= (dr_next == DR_ON);
      short_test_en <= (dr_next == DR_TEST);
      flash_mode    <= (dr_next == DR_ON) && flash_cmd;
    end
  end

  // (R11) flash default code, (R13) torch level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_level_code   <= FLASH_DEF[3:0];
      low_battery_code <= LB_DEF;
    end else begin
      led_level_code   <= level;
      low_battery_code <= lb_reg;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_boost;
    @(posedge core_clk) disable iff (!rst_n) boost_en == led_driver_en;
  endproperty
  a_boost: assert property (p_boost) // R19
    else $error("boost enable differs from driver enable");

  property p_shut;
    @(posedge core_clk) disable iff (!rst_n)
      shut_hit |=> shutdown && flash_reg == FLASH_DEF;
  endproperty
  a_shut: assert property (p_shut) // R05
    else $error("low line did not shut down");

  property p_count;
    @(posedge core_clk) disable iff (!rst_n)
      ln_state_reg == LN_RX && rise && !lat_hit && cnt_reg < 6'h3f
      && !shut_hit |=> cnt_reg == $past(cnt_reg) + 6'h01;
  endproperty
  a_count: assert property (p_count) // R02
    else $error("pulse not counted");

  property p_latch;
    @(posedge core_clk) disable iff (!rst_n)
      ln_state_reg == LN_RX && dc_s && lat_hit && words_reg == 2'd0
      |=> addr_sh_reg == $past(cnt_reg) && words_reg == 2'd1;
  endproperty
  a_latch: assert property (p_latch) // R21
    else $error("address word not latched");

  property p_frame;
    @(posedge core_clk) disable iff (!rst_n)
      frame_end && words_reg != 2'd2 |=> $stable(flash_reg)
      && $stable(torch_reg) && $stable(dur_reg);
  endproperty
  a_frame: assert property (p_frame) // R23
    else $error("bad frame changed a register");

  property p_max;
    @(posedge core_clk) disable iff (!rst_n)
      frame_end && addr_sh_reg == ADDR_THR && data_sh_reg > MAX_THR
      |=> $stable(thr_reg);
  endproperty
  a_max: assert property (p_max) // R24
    else $error("data above maximum accepted");

  property p_ovp;
    @(posedge core_clk) disable iff (!rst_n)
      pins_s[3] |=> ##1 !led_driver_en;
  endproperty
  a_ovp: assert property (p_ovp) // R16
    else $error("driver on during overvoltage");

  property p_lb;
    @(posedge core_clk) disable iff (!rst_n)
      dr_state_reg == DR_ON && pins_s[2] |=> !led_driver_en [*2];
  endproperty
  a_lb: assert property (p_lb) // R15
    else $error("driver on during low battery");

  property p_test;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(led_driver_en) |-> $past(short_test_en);
  endproperty
  a_test: assert property (p_test) // R17
    else $error("driver on without short test");

  c_write: cover property (@(posedge core_clk) frame_ok);
  c_shut:  cover property (@(posedge core_clk) shut_hit);
  c_on:    cover property (@(posedge core_clk) $rose(led_driver_en));
  c_lock:  cover property (@(posedge core_clk) dr_state_reg == DR_LOCK);
endmodule // flwc_ctrl

// >>> flwc_ctrl_tb_top.sv
// self-checking testbench of the flash led single wire control block
`timescale 1ns/100ps
`define FLWC_CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module flwc_ctrl_tb_top;
  import flwc_pkg::*;
  // ----------------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------------
  localparam int END_T = 4400;
  localparam int LIMIT = 80000;
  // fault pins are toggled through one vector, none is tied
  localparam logic [4:0] F_LB   = 5'h01;
  localparam logic [4:0] F_OV   = 5'h02;
  localparam logic [4:0] F_HOT  = 5'h04;
  localparam logic [4:0] F_COOL = 5'h08;
  localparam logic [4:0] F_SH   = 5'h10;
  logic       core_clk;
  logic       rst_n;
  logic       serial_enable_line;
  logic       flash_trigger_pin;
  logic       low_battery_detect;
  logic       output_overvoltage_protect;
  logic       temp_hot;
  logic       temp_cool;
  logic       led_short_fail;
  logic [4:0] flt;
  assign low_battery_detect         = flt[0];
  assign output_overvoltage_protect = flt[1];
  assign temp_hot                   = flt[2];
  assign temp_cool                  = flt[3];
  assign led_short_fail             = flt[4];
  logic       led_driver_en;
  logic       boost_en;
  logic       short_test_en;
  logic       flash_mode;
  logic [3:0] led_level_code;
  logic [3:0] low_battery_code;
  logic       shutdown;
  int         fails;
  int         samples_checked;
  int         cyc;
  logic [31:0] seed;
  logic [4:0] exp_q[$];
  logic [4:0] note;
  logic       d1;
  logic       d2;
  logic [3:0] r;
  logic [3:0] r2;

  flwc_ctrl #(.END_CYCLES(END_T), .SHORT_CYCLES(50), .SAFE_UNIT(100))
  u_flwc_ctrl (
    .core_clk                   (core_clk),
    .rst_n                      (rst_n),
    .serial_enable_line         (serial_enable_line),
    .flash_trigger_pin          (flash_trigger_pin),
    .low_battery_detect         (low_battery_detect),
    .output_overvoltage_protect (output_overvoltage_protect),
    .temp_hot                   (temp_hot),
    .temp_cool                  (temp_cool),
    .led_short_fail             (led_short_fail),
    .led_driver_en              (led_driver_en),
    .boost_en                   (boost_en),
    .short_test_en              (short_test_en),
    .flash_mode                 (flash_mode),
    .led_level_code             (led_level_code),
    .low_battery_code           (low_battery_code),
    .shutdown                   (shutdown)
  );

  flwc_host #(.LAT_WAIT(4000), .END_WAIT(4500)) u_flwc_host (
    .core_clk           (core_clk),
    .serial_enable_line (serial_enable_line)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic trig(input logic v);
    @(posedge core_clk);
    flash_trigger_pin <= v;
  endtask

  // bounded wait for the driver to reach a level
  task automatic wait_en(input logic v, input int lim);
    int k;
    k = 0;
    while (led_driver_en !== v && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    `FLWC_CHK("led_driver_en", v, led_driver_en)
  endtask

  // ----------------------------------------------------------------------
  // watcher: one note consumed per driver turn-on
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    d1 <= led_driver_en;
    d2 <= d1;
    if (d1 === 1'b1 && d2 === 1'b0) begin
      if (exp_q.size() == 0) begin
        `FLWC_CHK("unexpected turn-on", 1'b0, 1'b1)
      end else begin
        note = exp_q.pop_front();
        `FLWC_CHK("mode_level", note, {flash_mode, led_level_code})
      end
      `FLWC_CHK("boost_en", led_driver_en, boost_en)
    end
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    flash_trigger_pin = 1'b0;
    flt = F_COOL;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    seed = 32'h0000_9569;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `FLWC_CHK("shutdown", 1'b1, shutdown)
    `FLWC_CHK("led_level_code", 4'h4, led_level_code)
    u_flwc_host.drive(1'b1);
    u_flwc_host.idle(8);
    `FLWC_CHK("shutdown", 1'b0, shutdown)
    r = 4'(rnd() % 10);
    u_flwc_host.frame(4, int'(r));
    `FLWC_CHK("low_battery_code", r, low_battery_code)
    u_flwc_host.frame(4, 10);
    `FLWC_CHK("low_battery_code", r, low_battery_code)
    // threshold above its maximum: later torch timeout still expected
    u_flwc_host.frame(5, 6);
    u_flwc_host.word(4);
    u_flwc_host.idle(4500);
    `FLWC_CHK("low_battery_code", r, low_battery_code)
    u_flwc_host.frame(1, 15);
    `FLWC_CHK("led_driver_en", 1'b0, led_driver_en)
    exp_q.push_back({1'b1, 4'hf});
    trig(1'b1);
    wait_en(1'b1, 100);
    u_flwc_host.idle(800);
    `FLWC_CHK("led_driver_en", 1'b1, led_driver_en)
    trig(1'b0);
    wait_en(1'b0, 10);
    // short test fails: command ignored, not remembered
    flt <= flt ^ F_SH;
    trig(1'b1);
    u_flwc_host.idle(20);
    `FLWC_CHK("short_test_en", 1'b1, short_test_en)
    u_flwc_host.idle(80);
    `FLWC_CHK("led_driver_en", 1'b0, led_driver_en)
    `FLWC_CHK("short_test_en", 1'b0, short_test_en)
    trig(1'b0);
    flt <= flt ^ F_SH;
    exp_q.push_back({1'b1, 4'hf});
    trig(1'b1);
    wait_en(1'b1, 100);
    flt <= flt ^ F_OV;
    wait_en(1'b0, 10);
    flt <= flt ^ F_OV;
    trig(1'b0);
    trig(1'b1);
    u_flwc_host.idle(100);
    `FLWC_CHK("led_driver_en", 1'b0, led_driver_en)
    trig(1'b0);
    // a short low clears the latch; the stray word is dropped
    u_flwc_host.word(1);
    u_flwc_host.idle(4500);
    exp_q.push_back({1'b1, 4'hf});
    trig(1'b1);
    wait_en(1'b1, 100);
    flt <= flt ^ F_LB;
    wait_en(1'b0, 10);
    flt <= flt ^ F_LB;
    trig(1'b0);
    exp_q.push_back({1'b1, 4'hf});
    trig(1'b1);
    wait_en(1'b1, 100);
    flt <= flt ^ (F_COOL | F_HOT);
    wait_en(1'b0, 10);
    flt <= flt ^ F_HOT;
    trig(1'b0);
    trig(1'b1);
    u_flwc_host.idle(100);
    `FLWC_CHK("led_driver_en", 1'b0, led_driver_en)
    flt <= flt ^ F_COOL;
    trig(1'b0);
    exp_q.push_back({1'b1, 4'hf});
    trig(1'b1);
    wait_en(1'b1, 100);
    trig(1'b0);
    wait_en(1'b0, 10);
    // torch level above threshold: timer must cut it
    r2 = 4'(rnd() % 11);
    exp_q.push_back({1'b0, r2});
    u_flwc_host.frame(2, 16 + int'(r2));
    wait_en(1'b1, 200);
    wait_en(1'b0, 600);
    `FLWC_CHK("low_battery_code", r, low_battery_code)
    u_flwc_host.drive(1'b0);
    u_flwc_host.idle(4500);
    `FLWC_CHK("shutdown", 1'b1, shutdown)
    `FLWC_CHK("low_battery_code", 4'h0, low_battery_code)
    u_flwc_host.drive(1'b1);
    u_flwc_host.idle(8);
    `FLWC_CHK("led_level_code", 4'h4, led_level_code)
    end_of_test();
  end
endmodule // flwc_ctrl_tb_top

// >>> flwc_host.sv
// host gpio model driving the single wire link of the flash driver
`timescale 1ns/100ps
module flwc_host #(
  parameter int LAT_WAIT = 4000,
  parameter int END_WAIT = 4500
) (
  input  wire logic core_clk,
  output logic      serial_enable_line
);
  localparam int HALF = 4;

  // push-pull gpio, starts low so the device sits in shutdown
  initial serial_enable_line = 1'b0;

  // ----------------------------------------------------------------------
  // line primitives
  // ----------------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic drive(input logic v);
    @(posedge core_clk);
    serial_enable_line <= v;
  endtask

  // ----------------------------------------------------------------------
  // words and frames
  // ----------------------------------------------------------------------
  // one low-high pulse per count
  task automatic word(input int n);
    for (int i = 0; i < n; i++) begin
      drive(1'b0);
      idle(HALF);
      drive(1'b1);
      idle(HALF);
    end
  endtask

  task automatic frame(input int a, input int d);
    word(a);
    // high past latch timeout, well short of end time
    idle(LAT_WAIT);
    word(d);
    idle(END_WAIT);
  endtask
endmodule // flwc_host

// >>> flwc_pkg.sv
// constants and types shared by the flash led single wire control block
package flwc_pkg;

  // ----------------------------------------------------------------------
  // clock and line timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int LAT_US        = 97;
  localparam int END_US        = 405;
  localparam int SHORT_US      = 200;
  // least times, rounded up to whole cycles
  localparam int LAT_CYC   = (LAT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int END_CYC   = (END_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_CYC = (SHORT_US * 1000 + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int SAFE_UNIT_CYC = 1250000;

  // ----------------------------------------------------------------------
  // register addresses, maxima and defaults
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_FLASH  = 6'h01;
  localparam logic [5:0] ADDR_TORCH  = 6'h02;
  localparam logic [5:0] ADDR_DUR    = 6'h03;
  localparam logic [5:0] ADDR_LB     = 6'h04;
  localparam logic [5:0] ADDR_THR    = 6'h05;
  localparam logic [5:0] MAX_FLASH   = 6'h1f;
  localparam logic [5:0] MAX_TORCH   = 6'h1f;
  localparam logic [5:0] MAX_DUR     = 6'h07;
  localparam logic [5:0] MAX_LB      = 6'h09;
  localparam logic [5:0] MAX_THR     = 6'h05;
  localparam logic [4:0] FLASH_DEF   = 5'h04;
  localparam logic [4:0] TORCH_DEF   = 5'h04;
  localparam logic [2:0] DUR_DEF     = 3'h3;
  localparam logic [3:0] LB_DEF      = 4'h0;
  localparam logic [2:0] THR_DEF     = 3'h2;
  localparam int         EN_BIT      = 4;

  // ----------------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LN_SHUT = 3'b001,
    LN_IDLE = 3'b010,
    LN_RX   = 3'b100
  } flwc_line_t;

  typedef enum logic [3:0] {
    DR_OFF  = 4'b0001,
    DR_TEST = 4'b0010,
    DR_ON   = 4'b0100,
    DR_LOCK = 4'b1000
  } flwc_drv_t;

endpackage

// >>> flwc_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module flwc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // flwc_sync
